// file: dv/fmb_line_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Line front end: measures carrier periods, plays comparator bits
// ------------------------------------------------------------
module fmb_line_model import fmb_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic carrier_out,
  input wire logic carrier_en,
  input wire logic [15:0] bit_period,
  input wire logic [15:0] line_data,
  input wire logic line_go,
  output logic comp_in,
  output logic [8:0] per_seen,
  output logic line_busy
);
  logic prev_r;
  logic [8:0] pc_r;
  logic [4:0] idx_r;
  logic [15:0] cnt_r;
  logic [15:0] sr_r;
  wire logic rise = carrier_out && !prev_r && carrier_en;
  assign line_busy = (idx_r != 5'h0);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
      pc_r <= 9'h0;
      per_seen <= 9'h0;
    end else begin
      prev_r <= carrier_out;
      pc_r <= rise ? 9'h0 : pc_r + 9'h1;
      if (rise) per_seen <= pc_r + 9'h1;
    end
  end
  // With no carrier the comparator chatters, so idle toggles every cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idx_r <= 5'h0;
      cnt_r <= 16'h0;
      sr_r <= 16'h0;
      comp_in <= 1'b0;
    end else if (line_go && !line_busy) begin
      sr_r <= line_data;
      idx_r <= 5'h10;
      cnt_r <= bit_period - 16'h1;
      comp_in <= line_data[0];
    end else if (line_busy && cnt_r == 16'h0) begin
      sr_r <= sr_r >> 1;
      idx_r <= idx_r - 5'h1;
      cnt_r <= bit_period - 16'h1;
      comp_in <= (idx_r == 5'h1) ? ~comp_in : sr_r[1];
    end else if (line_busy) begin
      cnt_r <= cnt_r - 16'h1;
    end else begin
      comp_in <= ~comp_in;
    end
  end
endmodule // fmb_line_model
`default_nettype wire

// file: dv/tb_fmb_bit_engine.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_fmb_bit_engine import fmb_pkg::*; ;
  // ------------------------------------------------------------
  // Stimulus and instances
  // ------------------------------------------------------------
  localparam int P = 470;
  logic sys_clk = 0, rst = 1, alt_one_sel = 0, tx_byte_last = 0;
  logic tx_byte_valid = 0, rx_hunt = 0, line_go = 0;
  logic [15:0] bit_period = 16'h01d6, line_data = 16'h0;
  logic [7:0] tx_byte_data = 8'h0;
  wire logic tx_byte_ready, carrier_out, carrier_en, tx_busy, comp_in;
  wire logic rx_byte_valid, rx_in_packet, line_busy;
  wire logic [7:0] rx_byte_data;
  wire logic [8:0] per_seen;
  int n_fail = 0, checked = 0, cyc = 0, rx_cnt = 0, ce_cnt = 0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (rx_byte_valid === 1'b1) rx_cnt++;
    if (carrier_en === 1'b1) ce_cnt++;
    if (cyc == 100000) begin
      n_fail++;
      close_out();
    end
  end
  fmb_bit_engine #(.MIN_BIT(16'h0010)) fmb_bit_engine_inst (.sys_clk(sys_clk),
    .rst(rst), .bit_period(bit_period), .alt_one_sel(alt_one_sel),
    .tx_byte_data(tx_byte_data), .tx_byte_last(tx_byte_last),
    .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
    .carrier_out(carrier_out), .carrier_en(carrier_en), .tx_busy(tx_busy),
    .comp_in(comp_in), .rx_hunt(rx_hunt), .rx_byte_data(rx_byte_data),
    .rx_byte_valid(rx_byte_valid), .rx_in_packet(rx_in_packet));
  fmb_line_model fmb_line_model_inst (.sys_clk(sys_clk), .rst(rst),
    .carrier_out(carrier_out), .carrier_en(carrier_en),
    .bit_period(bit_period), .line_data(line_data), .line_go(line_go),
    .comp_in(comp_in), .per_seen(per_seen), .line_busy(line_busy));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic push(input logic [7:0] d, input logic l);
    @(posedge sys_clk);
    tx_byte_valid <= 1'b1;
    tx_byte_data <= d;
    tx_byte_last <= l;
    @(negedge sys_clk);
    while (tx_byte_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    tx_byte_valid <= 1'b0;
  endtask
  task automatic tx_case(input logic a, input logic [7:0] d);
    logic [15:0] bits;
    logic [8:0] dv;
    int r0;
    bits = {d, PREAMBLE};
    r0 = rx_cnt;
    @(posedge sys_clk);
    alt_one_sel <= a;
    push(d, 1'b1);
    while (carrier_en !== 1'b1) @(negedge sys_clk);
    `CHK("tx_busy", 1'b1, tx_busy)
    // The tone stays high across a bit boundary, so the first rise of a bit
    // spans two bits; the second and third rises in a bit give clean periods.
    for (int k = 0; k < 16; k++) begin
      repeat (k == 0 ? 350 : P) @(negedge sys_clk);
      dv = !bits[k] ? 9'h096 : (a ? 9'h099 : 9'h098);
      `CHK("period", dv, per_seen)
    end
    repeat (P - 353) @(negedge sys_clk);
    `CHK("carrier_en on", 1'b1, carrier_en)
    repeat (6) @(negedge sys_clk);
    `CHK("carrier_en off", 1'b0, carrier_en)
    `CHK("carrier_out", 1'b0, carrier_out)
    `CHK("rx in tx", r0, rx_cnt)
    $display("tx test done");
  endtask
  task automatic wait_rx;
    int k;
    k = 0;
    @(negedge sys_clk);
    while (rx_byte_valid !== 1'b1 && k < 20 * P) begin
      @(negedge sys_clk);
      k++;
    end
  endtask
  task automatic rx_case(input logic [7:0] d, input logic [7:0] first);
    int c0;
    c0 = ce_cnt;
    line_data <= {d, PREAMBLE};
    line_go <= 1'b1;
    @(posedge sys_clk);
    line_go <= 1'b0;
    wait_rx();
    `CHK("rx first", first, rx_byte_data)
    `CHK("in packet", 1'b1, rx_in_packet)
    if (first !== d) begin
      wait_rx();
      `CHK("rx next", d, rx_byte_data)
    end
    while (line_busy === 1'b1) @(negedge sys_clk);
    `CHK("no carrier in rx", c0, ce_cnt)
    $display("rx test done");
  endtask
  task automatic hunt_case;
    @(posedge sys_clk);
    rx_hunt <= 1'b1;
    @(posedge sys_clk);
    rx_hunt <= 1'b0;
    @(negedge sys_clk);
    `CHK("hunt", 1'b0, rx_in_packet)
    $display("hunt test done");
  endtask
  // Eight bytes fill the buffer while the preamble is still going out.
  task automatic fifo_case;
    @(posedge sys_clk);
    bit_period <= 16'h0010;
    for (int i = 0; i < 8; i++) push(8'(i * 37), i == 7);
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("full", 1'b0, tx_byte_ready)
    repeat (1100) @(negedge sys_clk);
    `CHK("busy", 1'b1, tx_busy)
    repeat (150) @(negedge sys_clk);
    `CHK("drained", 1'b0, tx_busy)
    `CHK("room", 1'b1, tx_byte_ready)
    $display("fifo test done");
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    tx_case(1'b0, 8'h3c);
    tx_case(1'b1, 8'hc5);
    rx_case(8'h5a, 8'h5a);
    rx_case(8'hc3, 8'hab);
    hunt_case();
    fifo_case();
    close_out();
  end
endmodule // tb_fmb_bit_engine
`default_nettype wire

// file: rtl/fmb_bit_engine.sv
`timescale 1ns/1ns
`default_nettype none
module fmb_bit_engine import fmb_pkg::*; #(
  parameter logic [15:0] MIN_BIT = MIN_BIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] bit_period,
  input wire logic alt_one_sel,
  input wire logic [7:0] tx_byte_data,
  input wire logic tx_byte_last,
  input wire logic tx_byte_valid,
  output logic tx_byte_ready,
  output logic carrier_out,
  output logic carrier_en,
  output logic tx_busy,
  input wire logic comp_in,
  input wire logic rx_hunt,
  output logic [7:0] rx_byte_data,
  output logic rx_byte_valid,
  output logic rx_in_packet
);
  // ---------------------------------------------------------------
  // Rate and transmit buffer
  // ---------------------------------------------------------------
  // Periods shorter than the 2400 bps limit are stretched to it.
  wire period_short = (bit_period < MIN_BIT);
  wire [15:0] period_eff = period_short ? MIN_BIT : bit_period;
  wire [15:0] period_half = period_eff >> 1;

  wire [TXW_W-1:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;
  wire fifo_ready;

  fmb_fifo #(.WIDTH(TXW_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_data({tx_byte_last, tx_byte_data}),
    .in_valid(tx_byte_valid),
    .in_ready(fifo_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  assign tx_byte_ready = fifo_ready;

  // ---------------------------------------------------------------
  // Transmit serializer
  // ---------------------------------------------------------------
  fmb_tx_state_type tx_state_r;
  fmb_tx_state_type tx_state_nxt;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_sh_nxt;
  logic [2:0] tx_idx_r;
  logic tx_last_r;
  logic tx_last_nxt;
  logic [15:0] tx_cnt_r;

  wire tx_active = (tx_state_r != TX_IDLE);
  wire tx_tick = tx_active && (tx_cnt_r == '0);
  wire tx_byte_end = tx_tick && (tx_idx_r == LAST_BIT_IDX);
  wire tx_need_next = (tx_state_r == TX_PRE) || !tx_last_r;
  // The preamble is sent while the first data byte waits in the buffer,
  // so the packet follows it with no gap.
  assign fifo_pop = tx_byte_end && tx_need_next && fifo_valid;
  wire tx_start = (tx_state_r == TX_IDLE) && fifo_valid;

  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_sh_nxt = tx_sh_r;
    tx_last_nxt = tx_last_r;
    case (tx_state_r)
      TX_IDLE: begin
        if (fifo_valid) begin
          tx_state_nxt = TX_PRE;
          tx_sh_nxt = PREAMBLE;
          tx_last_nxt = 1'b0;
        end
      end
      TX_PRE, TX_DATA: begin
        if (fifo_pop) begin
          tx_state_nxt = TX_DATA;
          tx_sh_nxt = fifo_data[7:0];
          tx_last_nxt = fifo_data[8];
        end else if (tx_byte_end) begin
          // A buffer underrun ends the packet rather than sending filler.
          tx_state_nxt = TX_IDLE;
        end else if (tx_tick) begin
          tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
        end
      end
      default: begin
        tx_state_nxt = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_state_r <= TX_IDLE;
      tx_sh_r <= '0;
      tx_last_r <= 1'b0;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_last_r <= tx_last_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_cnt_r <= '0;
      tx_idx_r <= '0;
    end else if (tx_start || tx_tick) begin
      tx_cnt_r <= period_eff - 16'h0001;
      tx_idx_r <= tx_start ? 3'h0 : tx_idx_r + 3'h1;
    end else if (tx_active) begin
      tx_cnt_r <= tx_cnt_r - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Carrier divider
  // ---------------------------------------------------------------
  logic [7:0] car_cnt_r;
  wire cur_bit = tx_sh_r[0];
  wire [7:0] one_div = alt_one_sel ? DIV_ALT : DIV_ONE;
  wire [7:0] cur_div = cur_bit ? one_div : DIV_ZERO;
  wire car_wrap = (car_cnt_r >= cur_div - 8'h01);
  wire car_high = (car_cnt_r < (cur_div >> 1));
  wire car_restart = !tx_active || tx_tick || car_wrap;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      car_cnt_r <= '0;
      carrier_out <= 1'b0;
      carrier_en <= 1'b0;
      tx_busy <= 1'b0;
    end else begin
      // Restart per bit so each bit opens on a full cycle of its tone.
      car_cnt_r <= car_restart ? '0 : car_cnt_r + 8'h01;
      carrier_out <= tx_active && car_high;
      carrier_en <= tx_active;
      tx_busy <= tx_active || fifo_valid;
    end
  end

  // ---------------------------------------------------------------
  // Receive deserializer
  // ---------------------------------------------------------------
  logic comp_d_r;
  logic [15:0] rx_cnt_r;
  logic [7:0] rx_sh_r;
  logic [2:0] rx_idx_r;
  logic rx_pkt_r;

  // Every comparator edge re-centres the sample point on the bit.
  wire rx_edge = (comp_in != comp_d_r);
  wire rx_fire = !rx_edge && (rx_cnt_r == '0);
  wire [7:0] rx_sh_nxt = {comp_in, rx_sh_r[7:1]};
  wire rx_found = rx_fire && !rx_pkt_r && (rx_sh_nxt == PREAMBLE);
  wire rx_done = rx_fire && rx_pkt_r && (rx_idx_r == LAST_BIT_IDX);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comp_d_r <= 1'b0;
      rx_cnt_r <= '0;
    end else begin
      comp_d_r <= comp_in;
      if (rx_edge) begin
        rx_cnt_r <= period_half;
      end else if (rx_fire) begin
        rx_cnt_r <= period_eff - 16'h0001;
      end else begin
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_sh_r <= '0;
      rx_idx_r <= '0;
      rx_pkt_r <= 1'b0;
      rx_byte_data <= '0;
      rx_byte_valid <= 1'b0;
      rx_in_packet <= 1'b0;
    end else begin
      rx_byte_valid <= 1'b0;
      if (tx_active || rx_hunt) begin
        // Our own carrier would echo back, so receive is held in hunt.
        rx_pkt_r <= 1'b0;
        rx_idx_r <= '0;
        rx_sh_r <= '0;
      end else if (rx_fire) begin
        rx_sh_r <= rx_sh_nxt;
        rx_idx_r <= rx_pkt_r ? rx_idx_r + 3'h1 : 3'h0;
        if (rx_found) begin
          rx_pkt_r <= 1'b1;
        end
        if (rx_done) begin
          rx_byte_data <= rx_sh_nxt;
          rx_byte_valid <= 1'b1;
        end
      end
      rx_in_packet <= rx_pkt_r && !tx_active && !rx_hunt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_min_rate_held: assert property (@(posedge sys_clk)
    disable iff (rst)
    period_eff >= MIN_BIT
      && (bit_period >= MIN_BIT || period_eff == MIN_BIT))
    else $error("Bit period below the 2400 bps limit.");

  a_preamble_first: assert property (@(posedge sys_clk)
    disable iff (rst)
    tx_start |=> tx_state_r == TX_PRE && tx_sh_r == PREAMBLE && tx_idx_r == 3'h0)
    else $error("Packet did not open with the preamble byte.");

  a_lsb_shift: assert property (@(posedge sys_clk) disable iff (rst)
    (tx_tick && tx_idx_r != LAST_BIT_IDX)
      |=> tx_sh_r == {1'b0, $past(tx_sh_r[7:1])})
    else $error("Transmit shift is not LSB first.");

  a_bit_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (tx_tick && tx_state_nxt != TX_IDLE)
      |=> tx_cnt_r == $past(period_eff) - 16'h0001 && $stable(period_eff)
      |-> ##1 !tx_tick)
    else $error("Bit period not reloaded on a bit boundary.");

  a_carrier_div: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && !tx_tick && !car_wrap
      |=> car_cnt_r == $past(car_cnt_r) + 8'h01)
    else $error("Carrier divider skipped a count.");

  a_zero_tone: assert property (@(posedge sys_clk) disable iff (rst)
    (tx_active && !cur_bit) |-> cur_div == DIV_ZERO)
    else $error("Zero bit not using the 133.3 kHz divider.");

  a_one_tone: assert property (@(posedge sys_clk) disable iff (rst)
    (tx_active && cur_bit) |-> cur_div == (alt_one_sel ? DIV_ALT : DIV_ONE))
    else $error("One bit using the wrong divider.");

  a_no_rx_in_tx: assert property (@(posedge sys_clk) disable iff (rst)
    carrier_en |-> !rx_byte_valid && !rx_in_packet)
    else $error("Received data delivered while transmitting.");

  a_quiet_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !carrier_en |-> !carrier_out)
    else $error("Carrier toggles while not transmitting.");

  a_rx_byte_out: assert property (@(posedge sys_clk) disable iff (rst)
    (rx_done && !tx_active && !rx_hunt)
      |=> rx_byte_valid && rx_byte_data == $past(rx_sh_nxt))
    else $error("Completed receive byte not handed up.");
endmodule // fmb_bit_engine
`default_nettype wire

// file: rtl/fmb_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module fmb_fifo import fmb_pkg::*; #(
  parameter int WIDTH = TXW_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic not_full_r;
  wire push = in_valid && not_full_r;
  wire pop = out_ready && (count_r != '0);
  wire [AW:0] count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

  assign in_ready = not_full_r;
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // The ready flag is a flop so the producer never sees a combinational path.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      not_full_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
      not_full_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule // fmb_fifo
`default_nettype wire

// file: shared/fmb_pkg.sv
// Operation
// - Bytes from the network layer go to the modulator one bit at a time.
// - The carrier is the clock divided by an integer factor chosen by the current bit.
// - A zero bit gives about 133.3 kHz and a one bit about 131.8 kHz.
// - A setting moves the one-bit carrier to about 130.4 kHz, zero unchanged.
// - Line rates up to 2400 bps are supported for transmit and receive.
// - Half duplex: no received data while sending; a send started mid-receive drops the receiver to hunt.
// - The receiver samples the comparator per bit and hands up whole bytes.
// - Each packet follows one preamble byte 0xab, which the receiver hunts.
package fmb_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int F_ZERO_HZ = 133_300;
  localparam int F_ONE_HZ = 131_800;
  localparam int F_ALT_HZ = 130_400;
  localparam int MAX_BPS = 2400;
  localparam logic [7:0] DIV_ZERO = 8'((CLK_HZ + F_ZERO_HZ / 2) / F_ZERO_HZ);
  localparam logic [7:0] DIV_ONE = 8'((CLK_HZ + F_ONE_HZ / 2) / F_ONE_HZ);
  localparam logic [7:0] DIV_ALT = 8'((CLK_HZ + F_ALT_HZ / 2) / F_ALT_HZ);
  // Shortest bit period allowed, rounded up so the rate never exceeds 2400.
  localparam logic [15:0] MIN_BIT_CYC = 16'((CLK_HZ + MAX_BPS - 1) / MAX_BPS);
  localparam logic [7:0] PREAMBLE = 8'hab;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  localparam int FIFO_DEPTH = 8;
  localparam int TXW_W = 9;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_PRE = 3'b010,
    TX_DATA = 3'b100
  } fmb_tx_state_type;
endpackage
